/* hw/aat_pkg.sv */
// constants, types and register map of the auxiliary converter readout
// assumes one 25 MHz core clock and a decoded memory-access port from the host link
//
// Contract
// - each result is an 8-bit unsigned value split over upper and lower readback registers
// - read upper to start, lower gives bits 1:0, upper again gives bits 7:2
// - in the receive state the signal-strength level feeds the converter regardless of select
// - converter powers up by itself in the receive state, no host write needed
// - outside receive, the source-select register at 0x359 picks the converter input
// - source-select value 0x08 routes the temperature sensor to the converter
// - one conversion takes about 1 microsecond after the initiating read
// - three inputs: temperature sensor, signal-strength level, one external analog pin
package aat_pkg;

  // ==========================================================================
  // bus and data widths
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADC_W  = 8;
  localparam int unsigned LOW_W  = 2;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] RX_PD_OFS   = 11'h324;
  localparam logic [ADDR_W-1:0] AUX_PD_OFS  = 11'h325;
  localparam logic [ADDR_W-1:0] RES_UP_OFS  = 11'h327;
  localparam logic [ADDR_W-1:0] RES_LO_OFS  = 11'h328;
  localparam logic [ADDR_W-1:0] SRC_SEL_OFS = 11'h359;

  // ==========================================================================
  // reset values and fields
  localparam logic [DATA_W-1:0] RX_PD_RST     = 8'h00;
  localparam logic [DATA_W-1:0] AUX_PD_RST    = 8'h00;
  localparam logic [DATA_W-1:0] SRC_SEL_RST   = 8'h00;
  localparam logic [ADC_W-1:0]  SAMPLE_RST    = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;
  localparam int unsigned       RX_ADC_EN_BIT   = 4;
  localparam int unsigned       AUX_TEMP_EN_BIT = 1;
  localparam logic [DATA_W-1:0] SRC_TEMP_CODE   = 8'h08;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_FREQ_KHZ = 25000;
  localparam int unsigned CONV_TIME_NS = 1000;
  // longest time: round down, at least one cycle
  localparam int unsigned CONV_CYC_RAW = CONV_TIME_NS * CLK_FREQ_KHZ / 1000000;
  localparam int unsigned CONV_CYC     = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam int unsigned STEP_CYC_RAW = CONV_CYC / ADC_W;
  localparam int unsigned STEP_CYC     = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    RB_IDLE = 4'b0001,
    RB_CONV = 4'b0010,
    RB_LOW  = 4'b0100,
    RB_HIGH = 4'b1000
  } aat_rb_state_t;

  typedef enum logic [2:0] {
    SRC_TEMP = 3'b001,
    SRC_RSSI = 3'b010,
    SRC_EXT  = 3'b100
  } aat_src_t;

endpackage : aat_pkg

/* hw/aat_sar.sv */
// successive-approximation sequencer: one trial bit per step, msb first
// assumes an analog comparator that reports 1 while the input is at or above dac_o
`timescale 1ns/1ps
module aat_sar #(
  parameter int unsigned W        = 8,
  parameter int unsigned STEP_CYC = 3
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         en_i,
  input  wire logic         start_i,
  input  wire logic         cmp_i,
  // results
  output logic [W-1:0]      dac_o,
  output logic              busy_o,
  output logic              done_o,
  output logic [W-1:0]      result_o
);

  localparam int unsigned CNT_W = (STEP_CYC < 2) ? 1 : $clog2(STEP_CYC);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYC - 1);
  localparam logic [W-1:0]     MSB_MASK = {1'b1, {(W-1){1'b0}}};

  if (W < 2 || STEP_CYC < 1) begin : g_chk
    $error("aat_sar: width or step count out of range");
  end

  // ==========================================================================
  // trial mask, partial code and step counter
  logic [W-1:0]     mask_q, mask_d;
  logic [W-1:0]     code_q, code_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             busy_q, busy_d;
  logic             done_q, done_d;

  always_comb begin
    mask_d = mask_q;
    code_d = code_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (!en_i) begin
      busy_d = 1'b0;
    end else if (start_i && !busy_q) begin
      busy_d = 1'b1;
      mask_d = MSB_MASK;
      code_d = MSB_MASK;
      cnt_d  = '0;
    end else if (busy_q) begin
      if (cnt_q == CNT_LAST) begin
        cnt_d = '0;
        // keep the trial bit only if the input sits at or above it
        code_d = cmp_i ? code_q : (code_q & ~mask_q);
        mask_d = mask_q >> 1;
        code_d = code_d | (mask_q >> 1);
        if (mask_q[0]) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q <= '0;
      code_q <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      code_q <= code_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign dac_o    = code_q;
  assign busy_o   = busy_q;
  assign done_o   = done_q;
  assign result_o = code_q;

endmodule : aat_sar

/* hw/aat_readout.sv */
// auxiliary converter readout: power and source control, register file, readback sequence
// assumes the host link delivers decoded single-byte register reads and writes,
// and that the radio core reports the receive state as a level
`timescale 1ns/1ps
module aat_readout
  import aat_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  // radio core
  input  wire logic                       rx_state_i,
  // register access port
  input  wire logic [aat_pkg::ADDR_W-1:0] mem_addr_i,
  input  wire logic                       mem_wr_i,
  input  wire logic                       mem_rd_i,
  input  wire logic [aat_pkg::DATA_W-1:0] mem_wdata_i,
  output logic      [aat_pkg::DATA_W-1:0] mem_rdata_o,
  output logic                            mem_rvalid_o,
  // analog front end
  input  wire logic                       cmp_i,
  output logic      [aat_pkg::ADC_W-1:0]  dac_code_o,
  output logic                            adc_pwr_en_o,
  output logic                            temp_sensor_en_o,
  output aat_pkg::aat_src_t               src_sel_o,
  // status
  output logic                            conv_busy_o
);

  import aat_pkg::*;

  // ==========================================================================
  // host-written registers
  logic [DATA_W-1:0] rx_pd_q, rx_pd_d;
  logic [DATA_W-1:0] aux_pd_q, aux_pd_d;
  logic [DATA_W-1:0] src_q, src_d;

  always_comb begin
    rx_pd_d  = rx_pd_q;
    aux_pd_d = aux_pd_q;
    src_d    = src_q;
    if (mem_wr_i) begin
      case (mem_addr_i)
        RX_PD_OFS: begin
          rx_pd_d = mem_wdata_i;
        end
        AUX_PD_OFS: begin
          aux_pd_d = mem_wdata_i;
        end
        SRC_SEL_OFS: begin
          src_d = mem_wdata_i;
        end
        default: begin
          rx_pd_d = rx_pd_q;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_pd_q  <= RX_PD_RST;
      aux_pd_q <= AUX_PD_RST;
      src_q    <= SRC_SEL_RST;
    end else begin
      rx_pd_q  <= rx_pd_d;
      aux_pd_q <= aux_pd_d;
      src_q    <= src_d;
    end
  end

  // ==========================================================================
  // power and input routing
  logic     adc_en_d, adc_en_q;
  logic     temp_en_d, temp_en_q;
  aat_src_t sel_d, sel_q;

  always_comb begin
    // receive state enables the converter on its own
    adc_en_d  = rx_state_i | rx_pd_q[RX_ADC_EN_BIT];
    temp_en_d = aux_pd_q[AUX_TEMP_EN_BIT];
    if (rx_state_i) begin
      sel_d = SRC_RSSI;
    end else if (src_q == SRC_TEMP_CODE) begin
      sel_d = SRC_TEMP;
    end else begin
      sel_d = SRC_EXT;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_en_q  <= 1'b0;
      temp_en_q <= 1'b0;
      sel_q     <= SRC_EXT;
    end else begin
      adc_en_q  <= adc_en_d;
      temp_en_q <= temp_en_d;
      sel_q     <= sel_d;
    end
  end

  // ==========================================================================
  // conversion engine
  logic             sar_start;
  logic             sar_busy;
  logic             sar_done;
  logic [ADC_W-1:0] sar_result;

  aat_sar #(
    .W        (ADC_W),
    .STEP_CYC (STEP_CYC)
  ) u_sar (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .en_i       (adc_en_q),
    .start_i    (sar_start),
    .cmp_i      (cmp_i),
    .dac_o      (dac_code_o),
    .busy_o     (sar_busy),
    .done_o     (sar_done),
    .result_o   (sar_result)
  );

  // ==========================================================================
  // readback sequence
  aat_rb_state_t    st_q, st_d;
  logic [ADC_W-1:0] held_q, held_d;
  logic             up_rd;
  logic             lo_rd;

  assign up_rd = mem_rd_i && (mem_addr_i == RES_UP_OFS);
  assign lo_rd = mem_rd_i && (mem_addr_i == RES_LO_OFS);

  always_comb begin
    st_d      = st_q;
    held_d    = held_q;
    sar_start = 1'b0;
    case (st_q)
      RB_IDLE: begin
        if (up_rd) begin
          // first upper read only starts a sample, and only while the converter is powered
          sar_start = adc_en_q;
          st_d      = adc_en_q ? RB_CONV : RB_LOW;
        end
      end
      RB_CONV: begin
        if (sar_done) begin
          held_d = sar_result;
          st_d   = RB_LOW;
        end else if (!adc_en_q) begin
          st_d = RB_LOW;
        end
      end
      RB_LOW: begin
        if (lo_rd) begin
          st_d = RB_HIGH;
        end else if (up_rd) begin
          // upper read out of order restarts the readback
          sar_start = adc_en_q;
          st_d      = adc_en_q ? RB_CONV : RB_LOW;
        end
      end
      RB_HIGH: begin
        if (up_rd) begin
          st_d = RB_IDLE;
        end
      end
      default: begin
        st_d = RB_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= RB_IDLE;
      held_q <= SAMPLE_RST;
    end else begin
      st_q   <= st_d;
      held_q <= held_d;
    end
  end

  // ==========================================================================
  // read data
  logic [DATA_W-1:0] rdata_d, rdata_q;
  logic              rvalid_q;

  always_comb begin
    rdata_d = UNMAPPED_DATA;
    case (mem_addr_i)
      RX_PD_OFS: begin
        rdata_d = rx_pd_q;
      end
      AUX_PD_OFS: begin
        rdata_d = aux_pd_q;
      end
      SRC_SEL_OFS: begin
        rdata_d = src_q;
      end
      RES_LO_OFS: begin
        rdata_d = DATA_W'(held_q[LOW_W-1:0]);
      end
      RES_UP_OFS: begin
        // the initiating read carries no sample bits
        if (st_q == RB_HIGH) begin
          rdata_d = DATA_W'(held_q[ADC_W-1:LOW_W]);
        end else begin
          rdata_d = UNMAPPED_DATA;
        end
      end
      default: begin
        rdata_d = UNMAPPED_DATA;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q  <= UNMAPPED_DATA;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= mem_rd_i ? rdata_d : rdata_q;
      rvalid_q <= mem_rd_i;
    end
  end

  // ==========================================================================
  // outputs
  assign mem_rdata_o      = rdata_q;
  assign mem_rvalid_o     = rvalid_q;
  assign adc_pwr_en_o     = adc_en_q;
  assign temp_sensor_en_o = temp_en_q;
  assign src_sel_o        = sel_q;
  assign conv_busy_o      = sar_busy;

endmodule : aat_readout

/* tb/aat_afe_model.sv */
// analog front end model: three source levels and the comparator
// assumes the bench sets each source level as an 8-bit code
`timescale 1ns/1ps
module aat_afe_model
  import aat_pkg::*;
(
  // converter side
  input  wire logic                      core_clk_i,
  input  wire logic [aat_pkg::ADC_W-1:0] dac_code_i,
  input  wire logic                      adc_pwr_en_i,
  input  wire logic                      temp_sensor_en_i,
  input  wire aat_pkg::aat_src_t         src_sel_i,
  // source levels and comparator output
  input  wire logic [aat_pkg::ADC_W-1:0] temp_lvl_i,
  input  wire logic [aat_pkg::ADC_W-1:0] rssi_lvl_i,
  input  wire logic [aat_pkg::ADC_W-1:0] ext_lvl_i,
  output logic                           cmp_o
);
  logic [ADC_W-1:0] lvl;
  logic             tgl = 1'b0;
  // an unpowered comparator chatters
  always @(posedge core_clk_i) tgl <= ~tgl;
  always_comb begin
    case (src_sel_i)
      SRC_TEMP: lvl = temp_sensor_en_i ? temp_lvl_i : 8'h00;
      SRC_RSSI: lvl = rssi_lvl_i;
      default:  lvl = ext_lvl_i;
    endcase
    cmp_o = adc_pwr_en_i ? (lvl >= dac_code_i) : tgl;
  end
endmodule : aat_afe_model

/* tb/aat_readout_props.sv */
// checker of the readout timing, source routing and readback format
// assumes it is bound to aat_readout and sees only its ports
`timescale 1ns/1ps
module aat_readout_chk
  import aat_pkg::*;
(
  // clock, reset, control
  input wire logic                       core_clk_i,
  input wire logic                       rst_i,
  input wire logic                       rx_state_i,
  input wire logic [aat_pkg::ADDR_W-1:0] mem_addr_i,
  input wire logic                       mem_wr_i,
  input wire logic                       mem_rd_i,
  input wire logic [aat_pkg::DATA_W-1:0] mem_wdata_i,
  input wire logic                       cmp_i,
  // design outputs
  input wire logic [aat_pkg::DATA_W-1:0] mem_rdata_o,
  input wire logic                       mem_rvalid_o,
  input wire logic [aat_pkg::ADC_W-1:0]  dac_code_o,
  input wire logic                       adc_pwr_en_o,
  input wire logic                       temp_sensor_en_o,
  input wire aat_pkg::aat_src_t          src_sel_o,
  input wire logic                       conv_busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // assertions
  rd_valid_a: assert property (mem_rd_i |=> mem_rvalid_o)
    else $error("read not answered");
  no_valid_a: assert property (!mem_rd_i |=> !mem_rvalid_o)
    else $error("stray read valid");
  rdata_hold_a: assert property (!mem_rvalid_o |-> $stable(mem_rdata_o))
    else $error("read data moved");
  low_fmt_a: assert property (mem_rd_i && mem_addr_i == RES_LO_OFS |=> mem_rdata_o[7:2] == 6'h00)
    else $error("lower readback format");
  up_fmt_a: assert property (mem_rd_i && mem_addr_i == RES_UP_OFS |=> mem_rdata_o[7:6] == 2'h0)
    else $error("upper readback format");
  conv_start_a: assert property ($rose(conv_busy_o) |-> $past(mem_rd_i) && dac_code_o == 8'h80)
    else $error("conversion started without read");
  conv_len_a: assert property ($rose(conv_busy_o) |->
    conv_busy_o [*8] ##16 conv_busy_o ##1 !conv_busy_o)
    else $error("conversion length");
  rx_src_a: assert property (rx_state_i |=> src_sel_o == SRC_RSSI)
    else $error("receive source");
  rx_pwr_a: assert property (rx_state_i |=> adc_pwr_en_o)
    else $error("receive power");
  temp_src_a: assert property (src_sel_o == SRC_TEMP |-> !$past(rx_state_i))
    else $error("temperature source in receive");
endmodule : aat_readout_chk

bind aat_readout aat_readout_chk u_chk (.core_clk_i, .rst_i, .rx_state_i, .mem_addr_i,
  .mem_wr_i, .mem_rd_i, .mem_wdata_i, .cmp_i, .mem_rdata_o, .mem_rvalid_o, .dac_code_o,
  .adc_pwr_en_o, .temp_sensor_en_o, .src_sel_o, .conv_busy_o);

/* tb/tb_top.sv */
// bench: register reads and writes walking the readback sequence on each source
// assumes the analog front end model on the converter side
`timescale 1ns/1ps
module tb_top;
  import aat_pkg::*;
  // ==========================================
  // signals
  logic              core_clk_i  = 1'b0;
  logic              rst_i       = 1'b1;
  logic              rx_state_i  = 1'b0;
  logic [ADDR_W-1:0] mem_addr_i  = 11'h000;
  logic              mem_wr_i    = 1'b0;
  logic              mem_rd_i    = 1'b0;
  logic [DATA_W-1:0] mem_wdata_i = 8'h00;
  logic [DATA_W-1:0] mem_rdata_o;
  logic [ADC_W-1:0]  dac_code_o;
  logic [ADC_W-1:0]  t_lvl       = 8'h3C;
  logic [ADC_W-1:0]  r_lvl       = 8'h5A;
  logic [ADC_W-1:0]  e_lvl       = 8'hA5;
  logic [ADC_W-1:0]  codes [3]   = '{8'h00, 8'hFF, 8'hA5};
  aat_src_t          src_sel_o;
  logic              mem_rvalid_o, cmp_i, adc_pwr_en_o, temp_sensor_en_o, conv_busy_o;
  int                err_count   = 0;
  int                check_count = 0;

  initial forever #20 core_clk_i = ~core_clk_i;

  aat_readout u_dut (.core_clk_i, .rst_i, .rx_state_i, .mem_addr_i, .mem_wr_i, .mem_rd_i,
    .mem_wdata_i, .mem_rdata_o, .mem_rvalid_o, .cmp_i, .dac_code_o, .adc_pwr_en_o,
    .temp_sensor_en_o, .src_sel_o, .conv_busy_o);
  aat_afe_model u_afe (.core_clk_i, .dac_code_i(dac_code_o), .adc_pwr_en_i(adc_pwr_en_o),
    .temp_sensor_en_i(temp_sensor_en_o), .src_sel_i(src_sel_o), .temp_lvl_i(t_lvl),
    .rssi_lvl_i(r_lvl), .ext_lvl_i(e_lvl), .cmp_o(cmp_i));

  // ==========================================
  // tasks, entered at a falling edge
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    mem_addr_i  = a;
    mem_wdata_i = d;
    mem_wr_i    = 1'b1;
    @(negedge core_clk_i);
    mem_wr_i = 1'b0;
    @(negedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    mem_addr_i = a;
    mem_rd_i   = 1'b1;
    @(negedge core_clk_i);
    mem_rd_i = 1'b0;
    chk({7'h00, mem_rvalid_o}, 8'h01);
    chk(mem_rdata_o, exp);
    @(negedge core_clk_i);
  endtask : rd

  // start, wait out the conversion, disturb every source, then read both halves
  task automatic rb(input logic [ADC_W-1:0] exp);
    rd(RES_UP_OFS, 8'h00);
    repeat (30) @(negedge core_clk_i);
    chk({7'h00, conv_busy_o}, 8'h00);
    {t_lvl, r_lvl, e_lvl} = ~{t_lvl, r_lvl, e_lvl};
    rd(RES_LO_OFS, {6'h00, exp[1:0]});
    rd(RES_UP_OFS, {2'h0, exp[7:2]});
  endtask : rb

  task automatic end_sim;
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ==========================================
  // sequence
  initial begin
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk({5'h00, src_sel_o}, {5'h00, SRC_EXT});
    rd(RX_PD_OFS, RX_PD_RST);
    rd(AUX_PD_OFS, AUX_PD_RST);
    rd(SRC_SEL_OFS, SRC_SEL_RST);
    rd(11'h300, UNMAPPED_DATA);
    rb(SAMPLE_RST);
    wr(RES_UP_OFS, 8'hFF);
    wr(RX_PD_OFS, 8'h10);
    chk({7'h00, adc_pwr_en_o}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      e_lvl = codes[i];
      rb(codes[i]);
    end
    // an upper read while the lower half is pending restarts the sample
    e_lvl = 8'h11;
    rd(RES_UP_OFS, 8'h00);
    repeat (30) @(negedge core_clk_i);
    e_lvl = 8'h66;
    rb(8'h66);
    wr(SRC_SEL_OFS, SRC_TEMP_CODE);
    wr(AUX_PD_OFS, 8'h02);
    chk({5'h00, src_sel_o}, {5'h00, SRC_TEMP});
    chk({7'h00, temp_sensor_en_o}, 8'h01);
    t_lvl = 8'h3C;
    rb(8'h3C);
    // second reading against the calibration point above
    t_lvl = 8'h50;
    rb(8'h50);
    rx_state_i = 1'b1;
    wr(RX_PD_OFS, 8'h00);
    chk({7'h00, adc_pwr_en_o}, 8'h01);
    chk({5'h00, src_sel_o}, {5'h00, SRC_RSSI});
    r_lvl = 8'hC3;
    rb(8'hC3);
    rx_state_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk({7'h00, adc_pwr_en_o}, 8'h00);
    chk({5'h00, src_sel_o}, {5'h00, SRC_TEMP});
    // reset in mid-run clears registers, routing and the held sample
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk({7'h00, adc_pwr_en_o}, 8'h00);
    chk({5'h00, src_sel_o}, {5'h00, SRC_EXT});
    rd(SRC_SEL_OFS, SRC_SEL_RST);
    rd(RES_LO_OFS, {6'h00, SAMPLE_RST[1:0]});
    end_sim();
  end
endmodule : tb_top
